// *** design/watchdog_timer.sv ***
// Watchdog timer core with its AHB-Lite register slave
// How it works
// - A 15-bit down-counter steps once per prescaler tick of the CPU clock.
// - Underflow past zero raises an interrupt event or a reset request.
// - The action select bit can only be set; writing zero has no effect.
// - On main, on-chip or PLL clock the prescaler divides by 16 or 128.
// - On sub-clock the prescaler always divides by 2.
// - Period equals prescaler ratio times 32768 ticks of the CPU clock.
// - Any write to the refresh register reinitialises the down-counter.
// - After reset prescaler is cleared; nothing counts until first refresh.
// - Stop and wait modes hold counter and prescaler; counting then resumes.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
module watchdog_timer (
	// Clock, reset and clock enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Power mode inputs
	input wire logic stop_mode,
	input wire logic wait_mode,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Watchdog outputs
	output logic irq,
	output logic wdt_reset_req
);
	// Software visible state
	logic underflow_action_select;
	logic prescale_divide_select;
	logic sub_clock;
	logic [0:0] status;
	logic [0:0] mask;

	// Counter state
	logic [14:0] count;
	logic active;
	logic underflow;

	// Bus data phase tracking
	logic wr_pend;
	logic [7:0] wr_addr;
	logic addr_ok;
	logic take;
	logic take_rd;
	logic take_wr;
	logic refresh_wr;
	logic status_rd;
	logic [31:0] next_rdata;
	logic [0:0] next_status;
	logic [0:0] next_mask;

	wdt_tick_if link ();

	wdt_prescaler u_pre (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.link(link)
	);

	// Offset within the map, word aligned, upper address bits all zero
	function automatic logic hits(input logic [31:0] addr,
		input logic [7:0] off);
		return (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
	endfunction : hits

	// Any mapped offset
	function automatic logic mapped(input logic [31:0] addr);
		return (addr[31:8] == 24'h00_0000) && (addr[1:0] == 2'b00) &&
			(addr[7:0] <= wdt_pkg::off_last);
	endfunction : mapped

	// Address phase acceptance
	assign take = hsel && htrans[1] && hready;
	assign take_rd = take && !hwrite;
	assign take_wr = take && hwrite;
	assign addr_ok = mapped(haddr);
	assign status_rd = take_rd && hits(haddr, wdt_pkg::off_status);
	assign refresh_wr = wr_pend && (wr_addr == wdt_pkg::off_refresh);

	// Prescaler steering
	assign link.sub_clock = sub_clock;
	assign link.divide_select = prescale_divide_select;
	assign link.clear = refresh_wr;
	assign link.run = active && !stop_mode && !wait_mode;

	// The slave never stalls; hsize is only ever a whole word here
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Write data phase follows the accepted address phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (ce) begin
			wr_pend <= take_wr && addr_ok;
			wr_addr <= take_wr ? haddr[7:0] : wr_addr;
		end
	end

	// Read mux, registered at the address phase so data stands in data phase
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hits(haddr, wdt_pkg::off_control)) begin
			next_rdata[wdt_pkg::bit_action_select] = underflow_action_select;
			next_rdata[wdt_pkg::bit_sub_clock] = sub_clock;
			next_rdata[wdt_pkg::bit_divide_select] = prescale_divide_select;
		end else if (hits(haddr, wdt_pkg::off_count)) begin
			next_rdata[14:0] = count;
		end else if (hits(haddr, wdt_pkg::off_status)) begin
			next_rdata[wdt_pkg::bit_underflow] = status[0];
		end else if (hits(haddr, wdt_pkg::off_mask)) begin
			next_rdata[wdt_pkg::bit_underflow] = mask[0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			if (take_rd) begin
				hrdata <= next_rdata;
			end
		end
	end

	// Control register; the action bit is sticky so a runaway program
	// cannot fall back to the softer interrupt response
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			underflow_action_select <=
				wdt_pkg::reset_control[wdt_pkg::bit_action_select];
			sub_clock <= wdt_pkg::reset_control[wdt_pkg::bit_sub_clock];
			prescale_divide_select <=
				wdt_pkg::reset_control[wdt_pkg::bit_divide_select];
		end else if (ce) begin
			if (wr_pend && (wr_addr == wdt_pkg::off_control)) begin
				underflow_action_select <= underflow_action_select |
					hwdata[wdt_pkg::bit_action_select];
				sub_clock <= hwdata[wdt_pkg::bit_sub_clock];
				prescale_divide_select <=
					hwdata[wdt_pkg::bit_divide_select];
			end
		end
	end

	// Mask register; irq uses the incoming mask so it never lags a write
	always_comb begin
		next_mask = mask;
		if (wr_pend && (wr_addr == wdt_pkg::off_mask)) begin
			next_mask = hwdata[wdt_pkg::bit_underflow];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mask <= wdt_pkg::reset_mask;
		end else if (ce) begin
			mask <= next_mask;
		end
	end

	// Underflow happens on the tick that finds the terminal count
	assign underflow = link.tick && active &&
		(count == wdt_pkg::count_terminal);

	// Down-counter; idle from reset until the first refresh write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count <= wdt_pkg::count_full;
			active <= 1'b0;
		end else if (ce) begin
			if (refresh_wr) begin
				count <= wdt_pkg::count_full;
				active <= 1'b1;
			end else if (link.tick) begin
				// Full scale reload makes each turn 32768 ticks long
				count <= count - 15'h0001;
			end
		end
	end

	// Status: read clears, but an event in the same cycle wins
	always_comb begin
		next_status = status;
		if (status_rd) begin
			next_status = 1'b0;
		end
		if (underflow && !underflow_action_select) begin
			next_status = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			status <= wdt_pkg::reset_status;
		end else if (ce) begin
			status <= next_status;
		end
	end

	// Interrupt level follows unmasked status in the same cycle, built from the next status and mask
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(next_status & next_mask);
		end
	end

	// Reset request holds until the system reset clears this block
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wdt_reset_req <= 1'b0;
		end else if (ce) begin
			if (underflow && underflow_action_select) begin
				wdt_reset_req <= 1'b1;
			end
		end
	end
endmodule : watchdog_timer

// *** design/wdt_pkg.sv ***
// Shared constants for the watchdog timer block
package wdt_pkg;

	// Register byte offsets
	localparam logic [7:0] off_control = 8'h00;
	localparam logic [7:0] off_refresh = 8'h04;
	localparam logic [7:0] off_count = 8'h08;
	localparam logic [7:0] off_status = 8'h0c;
	localparam logic [7:0] off_mask = 8'h10;
	localparam logic [7:0] off_last = 8'h10;

	// Control register field positions
	localparam int bit_action_select = 0;
	localparam int bit_sub_clock = 1;
	localparam int bit_divide_select = 7;

	// Status and mask field positions
	localparam int bit_underflow = 0;
	localparam int event_width = 1;

	// Counter geometry
	localparam int count_width = 15;
	localparam logic [14:0] count_full = 15'h7fff;
	localparam logic [14:0] count_terminal = 15'h0000;

	// Prescaler ratios
	localparam int pre_width = 7;
	localparam logic [6:0] ratio_low = 7'h0f;
	localparam logic [6:0] ratio_high = 7'h7f;
	localparam logic [6:0] ratio_sub = 7'h01;

	// Reset values
	localparam logic [31:0] reset_control = 32'h0000_0000;
	localparam logic [0:0] reset_mask = 1'h0;
	localparam logic [0:0] reset_status = 1'h0;

	// Terminal value of the prescaler for the chosen clock source and ratio
	function automatic logic [6:0] pre_terminal(input logic sub_clock,
		input logic divide_select);
		logic [6:0] term;
		term = divide_select ? ratio_high : ratio_low;
		if (sub_clock) begin
			term = ratio_sub;
		end
		return term;
	endfunction : pre_terminal

endpackage : wdt_pkg

// *** design/wdt_tick_if.sv ***
// Link between the watchdog core and its prescaler
interface wdt_tick_if;
	logic run;
	logic clear;
	logic sub_clock;
	logic divide_select;
	logic tick;
	logic [6:0] value;

	modport core (output run, output clear, output sub_clock,
		output divide_select, input tick, input value);
	modport pre (input run, input clear, input sub_clock,
		input divide_select, output tick, output value);
endinterface : wdt_tick_if

// *** design/wdt_prescaler.sv ***
// Prescaler that divides the CPU clock into watchdog ticks
module wdt_prescaler (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Link to the core
	wdt_tick_if.pre link
);
	logic [6:0] pre;
	logic [6:0] term;

	assign term = wdt_pkg::pre_terminal(link.sub_clock, link.divide_select);
	assign link.value = pre;

	// Prescaler position; held while not running
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pre <= 7'h00;
		end else if (ce) begin
			if (link.clear) begin
				pre <= 7'h00;
			end else if (link.run) begin
				if (pre >= term) begin
					pre <= 7'h00;
				end else begin
					pre <= pre + 7'h01;
				end
			end
		end
	end

	// One tick per full prescaler turn
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			link.tick <= 1'b0;
		end else if (ce) begin
			link.tick <= link.run && !link.clear && (pre >= term);
		end
	end
endmodule : wdt_prescaler

// *** sim/wdt_sva.sv ***
// Port-level assertion checker for the watchdog timer
module wdt_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic stop_mode,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// Watchdog outputs
	input wire logic irq,
	input wire logic wdt_reset_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [16:0] since_ref;
	logic started;
	logic take;
	assign take = hsel && htrans[1] && hready && ce;
	// Saturates, so a stale count can never wrap into a false pass
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			since_ref <= 17'h0;
			started <= 1'b0;
		end else if (take && hwrite &&
			haddr == {24'h0, wdt_pkg::off_refresh}) begin
			since_ref <= 17'h0;
			started <= 1'b1;
		end else if (!since_ref[16]) begin
			since_ref <= since_ref + 17'h1;
		end
	end
	sequence rd_at(logic [7:0] a);
		take && !hwrite && haddr == {24'h0, a};
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	chk_ready_up: assert property (!$past(rst) && $past(ce) |-> hreadyout)
		else $error("hreadyout low");
	chk_req_sticky: assert property (wdt_reset_req |=> wdt_reset_req)
		else $error("reset request dropped");
	chk_req_late: assert property ($rose(wdt_reset_req) |->
		started && since_ref[16]) else $error("reset request early");
	chk_count_width: assert property (rd_at(wdt_pkg::off_count) |=>
		hrdata[31:15] == 17'h0) else $error("count too wide");
	chk_refresh_zero: assert property (rd_at(wdt_pkg::off_refresh) |=>
		hrdata == 32'h0) else $error("refresh reads nonzero");
	chk_stat_clear: assert property (rd_at(wdt_pkg::off_status) |=>
		!irq) else $error("irq after status read");
	chk_stop_hold: assert property ((stop_mode && !hsel)[*3] |->
		$stable(irq) && $stable(wdt_reset_req)) else $error("moved in stop");
endmodule : wdt_sva

bind watchdog_timer wdt_sva wdt_sva_i (.*);

// *** sim/watchdog_timer_tb_top.sv ***
// Self-checking testbench for the watchdog timer
module watchdog_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic stop_mode = 1'b0;
	logic wait_mode = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	wire logic hreadyout, hresp, irq, wdt_reset_req;
	wire logic [31:0] hrdata;
	int n_errors = 0;
	int num_checks = 0;
	int t;
	logic [31:0] q, c0;
	// Ratio model: sub-clock overrides the divide select
	int ratio[$] = '{2, 16, 128, 2};
	logic [31:0] ctl[4] = '{32'h2, 32'h0, 32'h80, 32'h82};
	logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h7fff, 32'h0, 32'h0, 32'h0};
	always #2 clk_sys = ~clk_sys;
	watchdog_timer watchdog_timer_i (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .stop_mode(stop_mode), .wait_mode(wait_mode),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.irq(irq), .wdt_reset_req(wdt_reset_req));
	task print_verdict;
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wait_on(input int sel, input int lim);
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while ((sel == 0 ? hreadyout : sel == 1 ? irq : wdt_reset_req)
			!== 1'b1 && t < lim);
		if (t >= lim) begin
			n_errors++;
			print_verdict();
		end
	endtask : wait_on
	// Single word transfer; hrdata taken at the data-phase edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_on(0, 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_on(0, 20);
		q = hrdata;
	endtask : bus
	task irq_is(input logic exp);
		repeat (2) @(posedge clk_sys);
		check("irq", irq, exp);
	endtask : irq_is
	initial begin
		void'($urandom(32'hc336));
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		foreach (rv[i]) begin
			bus(1'b0, 8'(4 * i), 32'h0);
			check("reset value", q, rv[i]);
		end
		repeat (100) @(posedge clk_sys);
		bus(1'b0, wdt_pkg::off_count, 32'h0);
		check("idle count", q, 32'h7fff);
		// 1024 cycles after the reload hold exactly 1024/N ticks; the first
		// tick needs one extra cycle through the prescaler pipeline
		foreach (ctl[i]) begin
			bus(1'b1, wdt_pkg::off_control, ctl[i]);
			bus(1'b1, wdt_pkg::off_refresh, $urandom);
			bus(1'b0, wdt_pkg::off_count, 32'h0);
			c0 = q;
			check("reload", c0, 32'h7fff);
			repeat (1023) @(posedge clk_sys);
			bus(1'b0, wdt_pkg::off_count, 32'h0);
			check("ticks", c0 - q, 32'(1024 / ratio[i]));
		end
		// 200 frozen cycles inside a 1024 window at divide by 2
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, wdt_pkg::off_count, 32'h0);
			c0 = q;
			stop_mode <= (k == 0);
			wait_mode <= (k == 1);
			ce <= (k != 2);
			repeat (200) @(posedge clk_sys);
			stop_mode <= 1'b0;
			wait_mode <= 1'b0;
			ce <= 1'b1;
			repeat (822) @(posedge clk_sys);
			bus(1'b0, wdt_pkg::off_count, 32'h0);
			check("frozen ticks", c0 - q, 32'd412);
		end
		bus(1'b1, wdt_pkg::off_control, 32'h2);
		bus(1'b1, wdt_pkg::off_mask, 32'h1);
		bus(1'b1, wdt_pkg::off_refresh, $urandom);
		wait_on(1, 70000);
		check("period", t >= 65534 && t <= 65540, 1'b1);
		bus(1'b1, wdt_pkg::off_mask, 32'h0);
		irq_is(1'b0);
		bus(1'b1, wdt_pkg::off_mask, 32'h1);
		irq_is(1'b1);
		bus(1'b0, wdt_pkg::off_status, 32'h0);
		check("status", q, 32'h1);
		irq_is(1'b0);
		bus(1'b1, wdt_pkg::off_control, 32'h3);
		bus(1'b1, wdt_pkg::off_control, 32'h2);
		bus(1'b0, wdt_pkg::off_control, 32'h0);
		check("control", q, 32'h3);
		// Counter wraps from zero to full scale at underflow, so the next one needs no refresh
		wait_on(2, 70000);
		bus(1'b0, wdt_pkg::off_status, 32'h0);
		check("no event", {q[0], irq}, 32'h0);
		// Reset in mid-run drops the request and the sticky action bit
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check("request in reset", wdt_reset_req, 1'b0);
		rst <= 1'b0;
		@(posedge clk_sys);
		bus(1'b0, wdt_pkg::off_control, 32'h0);
		check("control after reset", q, 32'h0);
		print_verdict();
	end
endmodule : watchdog_timer_tb_top
